// *** rtl/tbt_trigger_table.v ***
// trigger bookkeeping table with hamming-protected rows
`timescale 1ns/1ps
`include "tbt_trigger_table_regs.vh"
module tbt_trigger_table (
   input  wire                    mclk,
   input  wire                    reset,
   input  wire                    data_path_reset_cmd,
   input  wire                    crossing_counter_reset_cmd,
   input  wire                    cmd_bypass,
   input  wire                    cmd_trig,
   input  wire [`TBT_UCODE_W-1:0] cmd_trig_ucode,
   input  wire [`TBT_POS_W-1:0]   cmd_trig_pos,
   input  wire                    ext_trig,
   input  wire [`TBT_BC_W-1:0]    latency,
   input  wire                    rd_done,
   output reg                     matrix_trig_reg,
   output reg  [`TBT_ID_W-1:0]    matrix_trig_id_reg,
   output reg                     rd_valid_reg,
   output reg  [`TBT_ID_W-1:0]    rd_id_reg,
   output reg  [`TBT_TAG_W-1:0]   rd_tag_reg,
   output reg  [`TBT_BC_W-1:0]    rd_bcid_reg,
   output reg                     corrected_reg,
   output reg                     full_reg,
   output reg                     overflow_reg,
   output reg  [`TBT_BC_W-1:0]    bc_count_reg
);

   // -------------------------------------
   // hamming helpers
   // -------------------------------------
   // encode data into positions 1..24, parity at powers of two
   function [`TBT_CW_W-1:0] ham_enc;
      input [`TBT_DATA_W-1:0] d;
      integer pos;
      integer di;
      integer p;
      reg [`TBT_CW_W-1:0] cw;
      begin
         cw = `TBT_CW_RST;
         di = 0;
         for (pos = 1; pos <= `TBT_CW_W; pos = pos + 1) begin
            if ((pos & (pos - 1)) != 0) begin
               cw[pos-1] = d[di];
               di = di + 1;
            end
         end
         for (p = 0; p < `TBT_SYN_W; p = p + 1) begin
            for (pos = 1; pos <= `TBT_CW_W; pos = pos + 1) begin
               if (((pos >> p) & 1) == 1 && pos != (1 << p))
                  cw[(1<<p)-1] = cw[(1<<p)-1] ^ cw[pos-1];
            end
         end
         ham_enc = cw;
      end
   endfunction

   // syndrome: position of a single flipped bit, zero if clean
   function [`TBT_SYN_W-1:0] ham_syn;
      input [`TBT_CW_W-1:0] cw;
      integer pos;
      integer p;
      reg [`TBT_SYN_W-1:0] s;
      begin
         s = {`TBT_SYN_W{1'b0}};
         for (p = 0; p < `TBT_SYN_W; p = p + 1) begin
            for (pos = 1; pos <= `TBT_CW_W; pos = pos + 1) begin
               if (((pos >> p) & 1) == 1)
                  s[p] = s[p] ^ cw[pos-1];
            end
         end
         ham_syn = s;
      end
   endfunction

   // correct one bit and pull the data back out
   function [`TBT_DATA_W-1:0] ham_dec;
      input [`TBT_CW_W-1:0] cw;
      input [`TBT_SYN_W-1:0] s;
      integer pos;
      integer di;
      reg [`TBT_CW_W-1:0] c;
      reg [`TBT_DATA_W-1:0] d;
      begin
         c = cw;
         d = {`TBT_DATA_W{1'b0}};
         di = 0;
         for (pos = 1; pos <= `TBT_CW_W; pos = pos + 1) begin
            if (s == pos)
               c[pos-1] = ~c[pos-1];
         end
         for (pos = 1; pos <= `TBT_CW_W; pos = pos + 1) begin
            if ((pos & (pos - 1)) != 0) begin
               d[di] = c[pos-1];
               di = di + 1;
            end
         end
         ham_dec = d;
      end
   endfunction

   // -------------------------------------
   // trigger source select
   // -------------------------------------
   wire                    trig;
   wire [`TBT_UCODE_W-1:0] trig_ucode;
   wire [`TBT_POS_W-1:0]   trig_pos;

   // no internal trigger source exists
   assign trig = cmd_bypass ? ext_trig : cmd_trig;
   assign trig_ucode = cmd_bypass ? `TBT_EXT_UCODE : cmd_trig_ucode;
   assign trig_pos = cmd_bypass ? `TBT_EXT_POS : cmd_trig_pos;

   // -------------------------------------
   // triplicated pointers and counter
   // -------------------------------------
   wire [`TBT_PTR_W-1:0] wp [0:`TBT_TMR_N-1];
   wire [`TBT_PTR_W-1:0] rp [0:`TBT_TMR_N-1];
   wire [`TBT_BC_W-1:0]  bc [0:`TBT_TMR_N-1];
   wire [`TBT_PTR_W-1:0] wr_v;
   wire [`TBT_PTR_W-1:0] rd_v;
   wire [`TBT_BC_W-1:0]  bc_v;
   wire [`TBT_PTR_W-1:0] wr_next;
   wire [`TBT_PTR_W-1:0] rd_next;
   wire [`TBT_BC_W-1:0]  bc_next;
   wire [`TBT_PTR_W-1:0] occ;
   wire [`TBT_PTR_W-1:0] occ_next;
   wire                  is_full;
   wire                  push;
   wire                  pop;
   wire                  drop;
   wire                  fwd;
   wire                  head_live;

   // bitwise two-of-three vote, one upset copy is outvoted
   genvar b;
   generate
      for (b = 0; b < `TBT_PTR_W; b = b + 1) begin : vote_ptr
         assign wr_v[b] = (wp[0][b] & wp[1][b]) | (wp[0][b] & wp[2][b])
                          | (wp[1][b] & wp[2][b]);
         assign rd_v[b] = (rp[0][b] & rp[1][b]) | (rp[0][b] & rp[2][b])
                          | (rp[1][b] & rp[2][b]);
      end
      for (b = 0; b < `TBT_BC_W; b = b + 1) begin : vote_bc
         assign bc_v[b] = (bc[0][b] & bc[1][b]) | (bc[0][b] & bc[2][b])
                          | (bc[1][b] & bc[2][b]);
      end
   endgenerate

   // occupancy and accept decisions
   assign occ = wr_v - rd_v;
   assign is_full = (occ == `TBT_FULL_DIFF);
   assign push = trig & ~is_full;
   assign pop = rd_done & rd_valid_reg;
   assign drop = trig & is_full;

   // next pointer and counter values
   assign wr_next = push ? wr_v + `TBT_PTR_ONE : wr_v;
   assign rd_next = pop ? rd_v + `TBT_PTR_ONE : rd_v;
   assign bc_next = crossing_counter_reset_cmd ? `TBT_BC_RST
                                               : bc_v + `TBT_BC_ONE;
   assign occ_next = wr_next - rd_next;

   // forward a row written this edge; head counts only while held
   assign fwd = push && (wr_v == rd_next);
   assign head_live = (occ_next != `TBT_PTR_RST);

   // each copy reloads from the vote, scrubbing a single upset
   genvar k;
   generate
      for (k = 0; k < `TBT_TMR_N; k = k + 1) begin : tmr
         reg [`TBT_PTR_W-1:0] wp_reg;
         reg [`TBT_PTR_W-1:0] rp_reg;
         reg [`TBT_BC_W-1:0]  bc_reg;
         assign wp[k] = wp_reg;
         assign rp[k] = rp_reg;
         assign bc[k] = bc_reg;
         always @(posedge mclk or posedge reset) begin
            if (reset) begin
               wp_reg <= `TBT_PTR_RST;
               rp_reg <= `TBT_PTR_RST;
               bc_reg <= `TBT_BC_RST;
            end else if (data_path_reset_cmd) begin
               wp_reg <= `TBT_PTR_RST;
               rp_reg <= `TBT_PTR_RST;
               bc_reg <= `TBT_BC_RST;
            end else begin
               wp_reg <= wr_next;
               rp_reg <= rd_next;
               bc_reg <= bc_next;
            end
         end
      end
   endgenerate

   // -------------------------------------
   // row storage
   // -------------------------------------
   reg  [`TBT_CW_W-1:0]   mem [0:`TBT_DEPTH-1];
   wire [`TBT_BC_W-1:0]   row_bcid;
   wire [`TBT_DATA_W-1:0] row_data;
   wire [`TBT_CW_W-1:0]   row_cw;
   wire [`TBT_TAG_W-1:0]  row_tag;
   wire                   fill_en;
   wire                   wipe_en;

   // crossing of the hits: counter plus offset minus latency
   assign row_bcid = bc_v + {{(`TBT_BC_W-`TBT_POS_W){1'b0}}, trig_pos}
                     - latency;
   assign row_tag = {trig_ucode, trig_pos};
   assign row_data = {row_tag, row_bcid};
   assign row_cw = ham_enc(row_data);

   // no row changes while the data path is being cleared
   assign fill_en = push && !data_path_reset_cmd;
   assign wipe_en = pop && !data_path_reset_cmd;

   // fill on push, wipe the row just read out
   always @(posedge mclk) begin
      if (fill_en)
         mem[wr_v[`TBT_ID_W-1:0]] <= row_cw;
      if (wipe_en)
         mem[rd_v[`TBT_ID_W-1:0]] <= `TBT_CW_RST;
   end

   // -------------------------------------
   // head of table, read with correction
   // -------------------------------------
   wire [`TBT_CW_W-1:0]   head_cw;
   wire [`TBT_SYN_W-1:0]  head_syn;
   wire [`TBT_DATA_W-1:0] head_data;
   wire [`TBT_TAG_W-1:0]  head_tag;
   wire [`TBT_BC_W-1:0]   head_bcid;
   wire                   head_bad;

   // forward a row written this cycle so readout never stalls
   assign head_cw = fwd ? row_cw : mem[rd_next[`TBT_ID_W-1:0]];
   assign head_syn = ham_syn(head_cw);
   assign head_data = ham_dec(head_cw, head_syn);

   // split the corrected row back into its fields
   assign head_tag = head_data[`TBT_DATA_W-1:`TBT_BC_W];
   assign head_bcid = head_data[`TBT_BC_W-1:0];
   assign head_bad = (head_syn != {`TBT_SYN_W{1'b0}});

   // -------------------------------------
   // output registers
   // -------------------------------------
   // pulse and row index towards the pixel matrix
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         matrix_trig_reg <= 1'b0;
         matrix_trig_id_reg <= {`TBT_ID_W{1'b0}};
      end else if (data_path_reset_cmd) begin
         matrix_trig_reg <= 1'b0;
         matrix_trig_id_reg <= {`TBT_ID_W{1'b0}};
      end else begin
         matrix_trig_reg <= push;
         matrix_trig_id_reg <= wr_v[`TBT_ID_W-1:0];
      end
   end

   // readout side: valid while any row is held
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_valid_reg <= 1'b0;
         rd_id_reg <= {`TBT_ID_W{1'b0}};
      end else if (data_path_reset_cmd) begin
         rd_valid_reg <= 1'b0;
         rd_id_reg <= {`TBT_ID_W{1'b0}};
      end else begin
         rd_valid_reg <= head_live;
         rd_id_reg <= rd_next[`TBT_ID_W-1:0];
      end
   end

   // head fields, held at zero while the table is empty
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_tag_reg <= {`TBT_TAG_W{1'b0}};
         rd_bcid_reg <= `TBT_BC_RST;
         corrected_reg <= 1'b0;
      end else if (data_path_reset_cmd) begin
         rd_tag_reg <= {`TBT_TAG_W{1'b0}};
         rd_bcid_reg <= `TBT_BC_RST;
         corrected_reg <= 1'b0;
      end else if (head_live) begin
         rd_tag_reg <= head_tag;
         rd_bcid_reg <= head_bcid;
         corrected_reg <= head_bad;
      end else begin
         rd_tag_reg <= {`TBT_TAG_W{1'b0}};
         rd_bcid_reg <= `TBT_BC_RST;
         corrected_reg <= 1'b0;
      end
   end

   // status: full level and sticky overflow
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         full_reg <= 1'b0;
         overflow_reg <= 1'b0;
      end else if (data_path_reset_cmd) begin
         full_reg <= 1'b0;
         overflow_reg <= 1'b0;
      end else begin
         full_reg <= (occ_next == `TBT_FULL_DIFF);
         overflow_reg <= overflow_reg | drop;
      end
   end

   // copy of the voted crossing counter
   always @(posedge mclk or posedge reset) begin
      if (reset)
         bc_count_reg <= `TBT_BC_RST;
      else if (data_path_reset_cmd)
         bc_count_reg <= `TBT_BC_RST;
      else
         bc_count_reg <= bc_next;
   end

endmodule

// *** rtl/tbt_trigger_table_regs.vh ***
// constants for the trigger bookkeeping table
`ifndef TBT_TRIGGER_TABLE_REGS_VH
`define TBT_TRIGGER_TABLE_REGS_VH

// ----------------------------------------
// clock
// ----------------------------------------
`define TBT_CLK_MHZ      40
`define TBT_CMD_CLK_MHZ  160

// ----------------------------------------
// table geometry
// ----------------------------------------
`define TBT_DEPTH        32
`define TBT_ID_W         5
`define TBT_PTR_W        6
`define TBT_FULL_DIFF    6'h20
`define TBT_PTR_RST      6'h00
`define TBT_PTR_ONE      6'h01
`define TBT_TMR_N        3

// ----------------------------------------
// row fields
// ----------------------------------------
`define TBT_UCODE_W      5
`define TBT_POS_W        2
`define TBT_TAG_W        7
`define TBT_BC_W         12
`define TBT_BC_RST       12'h000
`define TBT_BC_ONE       12'h001
`define TBT_DATA_W       19
`define TBT_CW_W         24
`define TBT_SYN_W        5
`define TBT_CW_RST       24'h000000

// ----------------------------------------
// external trigger path defaults
// ----------------------------------------
`define TBT_EXT_UCODE    5'h00
`define TBT_EXT_POS      2'h0

`endif

// *** testbench/tbt_readout_model.sv ***
// readout side that drains the table head after head
`timescale 1ns/1ps
module tbt_readout_model (
   input  wire mclk,
   input  wire reset,
   input  wire stall,
   output reg  rd_done
);
   // done held every cycle unless stalled, so pops run back to back
   always @(posedge mclk or posedge reset) begin
      if (reset)
         rd_done <= 1'b0;
      else
         rd_done <= !stall;
   end
endmodule

// *** testbench/tbt_trigger_table_assertions.sv ***
// concurrent checks on the trigger table ports
`timescale 1ns/1ps
`include "tbt_trigger_table_regs.vh"
module tbt_trigger_table_assertions (
   input wire                  mclk,
   input wire                  reset,
   input wire                  data_path_reset_cmd,
   input wire                  crossing_counter_reset_cmd,
   input wire                  cmd_bypass,
   input wire                  cmd_trig,
   input wire                  ext_trig,
   input wire                  rd_done,
   input wire                  matrix_trig_reg,
   input wire [`TBT_ID_W-1:0]  matrix_trig_id_reg,
   input wire                  rd_valid_reg,
   input wire [`TBT_ID_W-1:0]  rd_id_reg,
   input wire                  full_reg,
   input wire                  overflow_reg,
   input wire [`TBT_BC_W-1:0]  bc_count_reg
);
   // trigger chosen by the bypass select
   wire trg = cmd_bypass ? ext_trig : cmd_trig;
   wire clr = data_path_reset_cmd;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_pop;
      rd_valid_reg && rd_done && !clr;
   endsequence
   sequence s_bc_restart;
      bc_count_reg == 12'h000 ##1 bc_count_reg == 12'h001;
   endsequence
   take_trig_a: assert property (
      trg && !full_reg && !clr |=> matrix_trig_reg) else $error("trig lost");
   no_self_trig_a: assert property (
      matrix_trig_reg |-> $past(trg) && !$past(clr)) else $error("self trig");
   trig_id_a: assert property (
      matrix_trig_reg ##1 matrix_trig_reg
      |-> matrix_trig_id_reg == $past(matrix_trig_id_reg) + 5'h01)
      else $error("row id skipped");
   drop_full_a: assert property (
      full_reg && trg && !clr |=> overflow_reg && !matrix_trig_reg)
      else $error("full trigger kept");
   bc_step_a: assert property (
      !reset && !clr && !crossing_counter_reset_cmd
      |=> bc_count_reg == $past(bc_count_reg) + 12'h001)
      else $error("counter step");
   bc_clear_a: assert property (
      crossing_counter_reset_cmd && !clr |=> s_bc_restart)
      else $error("counter clear");
   path_clear_a: assert property (
      clr |=> !rd_valid_reg && !overflow_reg && !full_reg
      && !matrix_trig_reg && bc_count_reg == 12'h000)
      else $error("path clear");
   pop_order_a: assert property (
      s_pop |=> !rd_valid_reg || rd_id_reg == $past(rd_id_reg) + 5'h01)
      else $error("pop order");
endmodule
bind tbt_trigger_table tbt_trigger_table_assertions u_chk (.mclk, .reset,
   .data_path_reset_cmd, .crossing_counter_reset_cmd, .cmd_bypass,
   .cmd_trig, .ext_trig, .rd_done, .matrix_trig_reg, .matrix_trig_id_reg,
   .rd_valid_reg, .rd_id_reg, .full_reg, .overflow_reg, .bc_count_reg);

// *** testbench/tbt_trigger_table_tb_top.sv ***
// self-checking bench for the trigger table
`timescale 1ns/1ps
`include "tbt_trigger_table_regs.vh"
module tbt_trigger_table_tb_top;
   reg         mclk = 1'b0, reset = 1'b1, dpr = 1'b0, ccr = 1'b0;
   reg         byp = 1'b0, ctr = 1'b0, etr = 1'b0, stall = 1'b1;
   reg  [4:0]  uc = 5'h00;
   reg  [1:0]  ps = 2'h0;
   reg  [11:0] lat = 12'h00A, bcm = 12'h000, eb [0:31];
   wire        mt, rv, cor, full, ovf, rdn;
   wire [4:0]  mid, rid;
   wire [6:0]  rtag;
   wire [11:0] rbc, bc;
   integer     error_cnt = 0, n_tests = 0, cyc = 0, i;
   always #12.5 mclk = ~mclk;
   tbt_trigger_table dut (.mclk(mclk), .reset(reset),
      .data_path_reset_cmd(dpr), .crossing_counter_reset_cmd(ccr),
      .cmd_bypass(byp), .cmd_trig(ctr), .cmd_trig_ucode(uc),
      .cmd_trig_pos(ps), .ext_trig(etr), .latency(lat), .rd_done(rdn),
      .matrix_trig_reg(mt), .matrix_trig_id_reg(mid), .rd_valid_reg(rv),
      .rd_id_reg(rid), .rd_tag_reg(rtag), .rd_bcid_reg(rbc),
      .corrected_reg(cor), .full_reg(full), .overflow_reg(ovf),
      .bc_count_reg(bc));
   tbt_readout_model u_rd (.mclk(mclk), .reset(reset), .stall(stall),
      .rd_done(rdn));
   // expected crossing count and hang guard
   always @(posedge mclk or posedge reset) begin
      if (reset || dpr || ccr)
         bcm <= 12'h000;
      else
         bcm <= bcm + 12'h001;
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt = error_cnt + 1;
         results;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // 33 back-to-back triggers into a stalled table, then drain
   task fill_drain;
      begin
         for (i = 0; i < 34; i = i + 1) begin
            @(posedge mclk);
            ctr <= (i < 33);
            uc <= i[4:0];
            ps <= i[1:0];
            if (i < 32)
               eb[i] = bcm + 12'h001 + i[1:0] - lat;
            #1;
            if (i > 0) chk(mt, i < 33);
            if (i > 0 && i < 33) chk(mid, i - 1);
         end
         chk(ovf, 1);
         chk(full, 1);
         stall <= 1'b0;
         for (i = 0; i < 33; i = i + 1) begin
            @(posedge mclk);
            #1;
            chk(rv, i < 32);
            if (i < 32) begin
               chk(rid, i);
               chk(rtag, {i[4:0], i[1:0]});
               chk(rbc, eb[i]);
               chk(cor, 0);
            end
         end
         chk(ovf, 1);
      end
   endtask
   // bypass picks the external trigger, decoder pulse ignored
   task bypass_src;
      begin
         @(posedge mclk);
         byp <= 1'b1;
         ctr <= 1'b1;
         @(posedge mclk);
         ctr <= 1'b0;
         etr <= 1'b1;
         eb[0] = bcm + 12'h001 - lat;
         #1;
         chk(mt, 0);
         @(posedge mclk);
         etr <= 1'b0;
         #1;
         chk(mt, 1);
         chk(mid, 0);
         chk(rtag, 0);
         chk(rbc, eb[0]);
         @(posedge mclk);
         byp <= 1'b0;
      end
   endtask
   // counter reset, then path reset with a trigger in the same cycle
   task clears;
      begin
         ccr <= 1'b1;
         @(posedge mclk);
         ccr <= 1'b0;
         #1;
         chk(bc, 0);
         @(posedge mclk);
         dpr <= 1'b1;
         ctr <= 1'b1;
         #1;
         chk(bc, 1);
         @(posedge mclk);
         dpr <= 1'b0;
         ctr <= 1'b0;
         #1;
         chk(mt, 0);
         chk(ovf, 0);
         chk(rv, 0);
         chk(bc, bcm);
         @(posedge mclk);
         ctr <= 1'b1;
         uc <= 5'h03;
         ps <= 2'h2;
         eb[0] = bcm + 12'h003 - lat;
         @(posedge mclk);
         ctr <= 1'b0;
         #1;
         chk(mt, 1);
         chk(mid, 0);
         chk(rtag, 7'h0E);
         chk(rbc, eb[0]);
         @(posedge mclk);
      end
   endtask
   task results;
      begin
         if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // reset, start-up path clear, then the scenarios
   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      dpr <= 1'b1;
      @(posedge mclk);
      dpr <= 1'b0;
      fill_drain;
      bypass_src;
      clears;
      results;
   end
endmodule
